// ==== hdl/out_trig_pkg.sv ====
package out_trig_pkg;
  localparam int NUM_PINS = 4;

  // -----------------------------------------------------------------
  // register byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TRIG = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;
  localparam logic [7:0] REG_DELAY = 8'h0C;
  localparam logic [7:0] REG_START_TIME = 8'h10;
  localparam logic [7:0] REG_FILTER = 8'h14;
  localparam logic [7:0] REG_PINS = 8'h18;
  localparam logic [7:0] REG_DATA = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_NOW = 8'h24;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int C_ARM = 0;
  localparam int C_SW = 1;
  localparam int C_STOP = 2;
  localparam int T_MODE = 0;
  localparam int T_FALL = 2;
  localparam int T_START_SRC = 4;
  localparam int T_STB_EXT = 8;
  localparam int T_TB_EXT = 9;
  localparam int T_STB_SRC = 12;
  localparam int T_TB_PIN = 16;
  localparam int T_PAUSE_SRC = 20;
  localparam int T_PAUSE_EN = 24;
  localparam int T_PAUSE_LOW = 25;
  localparam int T_STB_INV = 26;
  localparam int F_EN = 0;
  localparam int F_PRESET = 4;
  localparam int F_CUST_N = 6;
  localparam int F_CUST_DIV = 16;
  localparam int P_DIR = 0;
  localparam int P_ROUTE = 4;
  localparam int S_STATE = 0;
  localparam int S_PAUSED = 2;
  localparam int S_FLT = 4;
  localparam int S_COUNT = 16;

  // -----------------------------------------------------------------
  // encodings and reset values
  // -----------------------------------------------------------------
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_EDGE = 2'h1;
  localparam logic [1:0] MODE_TIME = 2'h2;
  localparam logic [3:0] SRC_SW = 4'h0;
  localparam logic [3:0] SRC_AI_REF = 4'h1;
  localparam logic [3:0] SRC_AI_START = 4'h2;
  localparam logic [3:0] SRC_INTERNAL = 4'h3;
  localparam logic [1:0] ROUTE_STROBE = 2'h1;
  localparam logic [1:0] ROUTE_START = 2'h2;
  localparam logic [1:0] PRESET_SHORT = 2'h0;
  localparam logic [1:0] PRESET_MEDIUM = 2'h1;
  localparam logic [1:0] PRESET_LONG = 2'h2;
  localparam logic [15:0] DIV_RESET = 16'h0010;

  // -----------------------------------------------------------------
  // filter timing, in picoseconds
  // -----------------------------------------------------------------
  localparam longint CLK_PS = 20000;
  localparam longint FAST_FCLK_PS = 12500;
  localparam longint LONG_FCLK_PS = 10000000;
  localparam longint SHORT_PASS_PS = 112500;
  localparam longint MED_PASS_PS = 6400000;
  localparam longint LONG_PASS_PS = 2560000000;
  localparam logic [15:0] FAST_DIV = 16'((FAST_FCLK_PS / CLK_PS) < 1 ? 1 : (FAST_FCLK_PS / CLK_PS));
  localparam logic [15:0] LONG_DIV = 16'(LONG_FCLK_PS / CLK_PS);
  localparam logic [9:0] SHORT_N = 10'(SHORT_PASS_PS / FAST_FCLK_PS);
  localparam logic [9:0] MED_N = 10'(MED_PASS_PS / FAST_FCLK_PS);
  localparam logic [9:0] LONG_N = 10'(LONG_PASS_PS / LONG_FCLK_PS);

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_RUN} gen_state_t;
endpackage

// ==== hdl/output_timing_trigger_filter.sv ====
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns
// Operation
// [RULE1] strobe updates all task outputs together
// [RULE2] strobe external or divided internal timebase
// [RULE3] timebase never driven onto a pin
// [RULE4] strobe routable to pins, active high; the code drives it active low when T_STB_INV is set
// [RULE5] start trigger, else software start command
// [RULE6] delay from start to first sample; the code skips it when T_STB_EXT selects an outside strobe
// [RULE7] start source and edge are selectable
// [RULE8] start at configured absolute time
// [RULE9] routed start trigger is high pulse
// [RULE10] pause masks samples from next boundary
// [RULE11] onboard strobe resumes at once
// [RULE12] outside strobe resumes on next edge
// [RULE13] pause source and level selectable
// [RULE14] strobe, start, pause go through filter
// [RULE15] each pin timing input or output
// [RULE16] per-pin filter enable, off at reset
// [RULE17] filter clock derived from timebase; the code divides it from pclk even when T_TB_EXT selects a pin timebase
// [RULE18] level passes after N agreeing samples
// [RULE19] short, medium and long filter presets
// [RULE20] custom filter clock and count
// [RULE21] jitter equals one filter clock period
// [RULE22] disagreeing sample restarts the count
module output_timing_trigger_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [out_trig_pkg::NUM_PINS-1:0] pin_in,
  output logic [out_trig_pkg::NUM_PINS-1:0] pin_out,
  output logic [out_trig_pkg::NUM_PINS-1:0] pin_oe_n,
  input wire logic analog_in_reference_trigger,
  input wire logic analog_in_start_trigger,
  input wire logic internal_event,
  output logic do_update,
  output logic [7:0] do_data
);

  typedef struct packed {
    logic [out_trig_pkg::NUM_PINS-1:0] pin_s1;
    logic [out_trig_pkg::NUM_PINS-1:0] pin_s2;
    logic [out_trig_pkg::NUM_PINS-1:0] flt;
    logic [out_trig_pkg::NUM_PINS-1:0][9:0] fcnt;
    logic [15:0] fdiv;
    logic [31:0] trig;
    logic [31:0] filter;
    logic [31:0] pins;
    logic [15:0] div;
    logic [31:0] delay;
    logic [31:0] start_time;
    logic [7:0] data;
    logic [31:0] now;
    out_trig_pkg::gen_state_t st;
    logic [15:0] tb_cnt;
    logic [31:0] dly_cnt;
    logic start_prev;
    logic stb_prev;
    logic tb_prev;
    logic paused;
    logic [15:0] samples;
    logic start_pulse;
    logic do_update;
    logic [7:0] do_data;
    logic [out_trig_pkg::NUM_PINS-1:0] pin_out;
    logic [out_trig_pkg::NUM_PINS-1:0] pin_oe_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s;
  state_t next_s;

  // ---------------------------------------------------------------
  // source selection shared by start, strobe and pause
  // ---------------------------------------------------------------
  function automatic logic pick_src(input logic [3:0] code, input logic [out_trig_pkg::NUM_PINS-1:0] pins,
                                    input logic swp, input logic ai_ref, input logic ai_st, input logic intl);
    logic r;
    r = 1'b0;
    if (code[3]) begin
      r = pins[code[1:0]];
    end else begin
      case (code)
        out_trig_pkg::SRC_SW: r = swp;
        out_trig_pkg::SRC_AI_REF: r = ai_ref;
        out_trig_pkg::SRC_AI_START: r = ai_st;
        out_trig_pkg::SRC_INTERNAL: r = intl;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  logic wr_en;
  logic arm_cmd;
  logic sw_cmd;
  logic stop_cmd;
  logic ftick;
  logic [15:0] flim;
  logic [9:0] nreq;
  logic start_v;
  logic start_edge;
  logic trig_hit;
  logic stb_v;
  logic tb_v;
  logic tb_tick;
  logic pause_now;
  logic sample;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // software commands act at the apb commit edge only
    wr_en = psel && penable && s.pready && pwrite;
    arm_cmd = wr_en && (paddr == out_trig_pkg::REG_CTRL) && pwdata[out_trig_pkg::C_ARM];
    sw_cmd = wr_en && (paddr == out_trig_pkg::REG_CTRL) && pwdata[out_trig_pkg::C_SW];
    stop_cmd = wr_en && (paddr == out_trig_pkg::REG_CTRL) && pwdata[out_trig_pkg::C_STOP];

    // pins cross in from outside: two flops before anything looks at them
    next_s.pin_s1 = pin_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.now = s.now + 32'h00000001;

    // filter clock is an enable pulse divided from pclk
    case (s.filter[out_trig_pkg::F_PRESET +: 2]) // RULE19 RULE20
      out_trig_pkg::PRESET_SHORT: begin
        flim = out_trig_pkg::FAST_DIV;
        nreq = out_trig_pkg::SHORT_N;
      end
      out_trig_pkg::PRESET_MEDIUM: begin
        flim = out_trig_pkg::FAST_DIV;
        nreq = out_trig_pkg::MED_N;
      end
      out_trig_pkg::PRESET_LONG: begin
        flim = out_trig_pkg::LONG_DIV;
        nreq = out_trig_pkg::LONG_N;
      end
      default: begin
        flim = s.filter[out_trig_pkg::F_CUST_DIV +: 16];
        nreq = s.filter[out_trig_pkg::F_CUST_N +: 10];
      end
    endcase
    ftick = ({1'b0, s.fdiv} + 17'h00001) >= {1'b0, flim}; // RULE17 RULE21
    next_s.fdiv = ftick ? 16'h0000 : s.fdiv + 16'h0001;

    // per-pin debounce; a disabled filter passes the synced level straight on
    for (int k = 0; k < out_trig_pkg::NUM_PINS; k++) begin
      if (!s.filter[out_trig_pkg::F_EN + k]) begin // RULE16
        next_s.flt[k] = s.pin_s2[k];
        next_s.fcnt[k] = 10'h000;
      end else if (ftick) begin
        if (s.pin_s2[k] == s.flt[k]) begin
          next_s.fcnt[k] = 10'h000; // RULE22
        end else if (({1'b0, s.fcnt[k]} + 11'h001) >= {1'b0, nreq}) begin
          next_s.flt[k] = s.pin_s2[k]; // RULE18
          next_s.fcnt[k] = 10'h000;
        end else begin
          next_s.fcnt[k] = s.fcnt[k] + 10'h001;
        end
      end
    end

    // trigger, strobe and pause sources read filtered pins
    start_v = pick_src(s.trig[out_trig_pkg::T_START_SRC +: 4], s.flt, sw_cmd, analog_in_reference_trigger,
                       analog_in_start_trigger, internal_event); // RULE7 RULE14
    stb_v = pick_src(s.trig[out_trig_pkg::T_STB_SRC +: 4], s.flt, sw_cmd, analog_in_reference_trigger,
                     analog_in_start_trigger, internal_event); // RULE14
    pause_now = s.trig[out_trig_pkg::T_PAUSE_EN] &&
                (pick_src(s.trig[out_trig_pkg::T_PAUSE_SRC +: 4], s.flt, sw_cmd, analog_in_reference_trigger,
                          analog_in_start_trigger, internal_event) ^ s.trig[out_trig_pkg::T_PAUSE_LOW]); // RULE13
    next_s.start_prev = start_v;
    next_s.stb_prev = stb_v;
    start_edge = s.trig[out_trig_pkg::T_FALL] ? (s.start_prev && !start_v) : (!s.start_prev && start_v); // RULE7
    case (s.trig[out_trig_pkg::T_MODE +: 2])
      out_trig_pkg::MODE_NONE: trig_hit = sw_cmd; // RULE5
      out_trig_pkg::MODE_EDGE: trig_hit = start_edge;
      out_trig_pkg::MODE_TIME: trig_hit = (s.now == s.start_time); // RULE8
      default: trig_hit = 1'b0;
    endcase

    // timebase is unfiltered and stays internal: no pin route reaches it
    tb_v = s.pin_s2[s.trig[out_trig_pkg::T_TB_PIN +: 2]]; // RULE3 RULE14
    next_s.tb_prev = tb_v;
    tb_tick = s.trig[out_trig_pkg::T_TB_EXT] ? (tb_v && !s.tb_prev) : 1'b1; // RULE2
    next_s.paused = pause_now && (s.st == out_trig_pkg::ST_RUN);

    // generation sequencer
    sample = 1'b0;
    next_s.start_pulse = 1'b0;
    case (s.st)
      out_trig_pkg::ST_IDLE: begin
        if (arm_cmd) begin
          next_s.st = out_trig_pkg::ST_ARMED;
        end
      end
      out_trig_pkg::ST_ARMED: begin
        if (trig_hit) begin
          next_s.start_pulse = 1'b1; // RULE9
          next_s.tb_cnt = s.div - 16'h0001;
          next_s.dly_cnt = 32'h00000000;
          if (!s.trig[out_trig_pkg::T_STB_EXT] && (s.delay != 32'h00000000)) begin
            next_s.st = out_trig_pkg::ST_DELAY; // RULE6
          end else begin
            next_s.st = out_trig_pkg::ST_RUN;
          end
        end
      end
      out_trig_pkg::ST_DELAY: begin
        next_s.dly_cnt = s.dly_cnt + 32'h00000001;
        if (({1'b0, s.dly_cnt} + 33'h000000001) >= {1'b0, s.delay}) begin
          next_s.st = out_trig_pkg::ST_RUN; // RULE6
        end
      end
      out_trig_pkg::ST_RUN: begin
        if (s.trig[out_trig_pkg::T_STB_EXT]) begin
          // a strobe edge seen while paused is dropped, so resuming waits for the next one
          sample = !s.stb_prev && stb_v && !pause_now; // RULE2 RULE10 RULE12
        end else if (tb_tick && !pause_now) begin
          // the divider freezes while paused and carries on the moment pause drops
          if (({1'b0, s.tb_cnt} + 17'h00001) >= {1'b0, s.div}) begin // RULE11
            sample = 1'b1;
            next_s.tb_cnt = 16'h0000;
          end else begin
            next_s.tb_cnt = s.tb_cnt + 16'h0001;
          end
        end
      end
      default: next_s.st = out_trig_pkg::ST_IDLE;
    endcase
    if (stop_cmd) begin
      next_s.st = out_trig_pkg::ST_IDLE;
    end

    // all task channels load from one data word in the same cycle
    next_s.do_update = sample;
    if (sample) begin
      next_s.do_data = s.data; // RULE1
      next_s.samples = s.samples + 16'h0001;
    end

    // pin drivers; enable low while driving
    for (int k = 0; k < out_trig_pkg::NUM_PINS; k++) begin
      next_s.pin_oe_n[k] = !s.pins[out_trig_pkg::P_DIR + k]; // RULE15
      case (s.pins[out_trig_pkg::P_ROUTE + 2 * k +: 2])
        out_trig_pkg::ROUTE_STROBE: next_s.pin_out[k] = sample ^ s.trig[out_trig_pkg::T_STB_INV]; // RULE4
        out_trig_pkg::ROUTE_START: next_s.pin_out[k] = next_s.start_pulse; // RULE9
        default: next_s.pin_out[k] = 1'b0;
      endcase
    end

    // apb slave: answer prepared in setup, pready high for one access cycle
    next_s.pready = psel && !penable;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h00000000;
    if (psel && !penable) begin
      case (paddr)
        out_trig_pkg::REG_CTRL: next_s.prdata = 32'h00000000;
        out_trig_pkg::REG_TRIG: next_s.prdata = s.trig;
        out_trig_pkg::REG_DIV: next_s.prdata = {16'h0000, s.div};
        out_trig_pkg::REG_DELAY: next_s.prdata = s.delay;
        out_trig_pkg::REG_START_TIME: next_s.prdata = s.start_time;
        out_trig_pkg::REG_FILTER: next_s.prdata = s.filter;
        out_trig_pkg::REG_PINS: next_s.prdata = s.pins;
        out_trig_pkg::REG_DATA: next_s.prdata = {24'h000000, s.data};
        out_trig_pkg::REG_STATUS: begin
          next_s.prdata[out_trig_pkg::S_STATE +: 2] = s.st;
          next_s.prdata[out_trig_pkg::S_PAUSED] = s.paused;
          next_s.prdata[out_trig_pkg::S_FLT +: out_trig_pkg::NUM_PINS] = s.flt;
          next_s.prdata[out_trig_pkg::S_COUNT +: 16] = s.samples;
        end
        out_trig_pkg::REG_NOW: next_s.prdata = s.now;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        out_trig_pkg::REG_TRIG: next_s.trig = pwdata;
        out_trig_pkg::REG_DIV: next_s.div = pwdata[15:0];
        out_trig_pkg::REG_DELAY: next_s.delay = pwdata;
        out_trig_pkg::REG_START_TIME: next_s.start_time = pwdata;
        out_trig_pkg::REG_FILTER: next_s.filter = pwdata;
        out_trig_pkg::REG_PINS: next_s.pins = pwdata;
        out_trig_pkg::REG_DATA: next_s.data = pwdata[7:0];
        default: next_s.data = s.data;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= out_trig_pkg::ST_IDLE;
      s.div <= out_trig_pkg::DIV_RESET;
      s.pin_oe_n <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pin_out = s.pin_out;
  assign pin_oe_n = s.pin_oe_n;
  assign do_update = s.do_update;
  assign do_data = s.do_data;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  update_data_a: assert property (sample |=> do_update && do_data == $past(s.data)) // RULE1
    else $error("update strobe did not load the data word");
  strobe_pin_a: assert property (sample && s.pins[out_trig_pkg::P_ROUTE + 4 +: 2] == out_trig_pkg::ROUTE_STROBE &&
      !s.trig[out_trig_pkg::T_STB_INV] |=> pin_out[2]) // RULE4
    else $error("routed strobe missing on pin 2");
  soft_start_a: assert property (s.st == out_trig_pkg::ST_ARMED && s.trig[out_trig_pkg::T_MODE +: 2] ==
      out_trig_pkg::MODE_NONE && sw_cmd && !stop_cmd |=>
      s.st inside {out_trig_pkg::ST_RUN, out_trig_pkg::ST_DELAY}) // RULE5
    else $error("software start ignored");
  delay_quiet_a: assert property (s.st == out_trig_pkg::ST_DELAY |=> !do_update) // RULE6
    else $error("sample issued during start delay");
  edge_start_a: assert property (s.st == out_trig_pkg::ST_ARMED && s.trig[out_trig_pkg::T_MODE +: 2] ==
      out_trig_pkg::MODE_EDGE && start_edge |=> s.start_pulse) // RULE7
    else $error("start edge not taken");
  time_start_a: assert property (s.st == out_trig_pkg::ST_ARMED && s.trig[out_trig_pkg::T_MODE +: 2] ==
      out_trig_pkg::MODE_TIME && s.now == s.start_time |=> s.st != out_trig_pkg::ST_ARMED) // RULE8
    else $error("time trigger missed");
  start_pulse_a: assert property (s.st == out_trig_pkg::ST_ARMED && trig_hit &&
      s.pins[out_trig_pkg::P_ROUTE + 2 +: 2] == out_trig_pkg::ROUTE_START |=> pin_out[1] ##1 !pin_out[1]) // RULE9
    else $error("routed start pulse not one cycle high");
  pause_mask_a: assert property (s.st == out_trig_pkg::ST_RUN && pause_now |=> !do_update) // RULE10
    else $error("sample issued while paused");
  filter_pass_a: assert property (s.filter[out_trig_pkg::F_EN] && $past(s.filter[out_trig_pkg::F_EN]) &&
      $changed(s.flt[0]) |->
      s.flt[0] == $past(s.pin_s2[0]) && $past(ftick)) // RULE18
    else $error("filter passed a level without a filter clock");
  glitch_reset_a: assert property (s.filter[out_trig_pkg::F_EN] && ftick && s.pin_s2[0] == s.flt[0] |=>
      s.fcnt[0] == 10'h000) // RULE22
    else $error("filter count not restarted");

endmodule

// ==== verification/trig_source_model.sv ====
`timescale 1ns/1ns
// -----------------------------------------------------------------
// far-side trigger sources and pin wiring
// -----------------------------------------------------------------
module trig_source_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [out_trig_pkg::NUM_PINS-1:0] req_pin,
  input wire logic req_ref,
  input wire logic req_start,
  input wire logic req_int,
  input wire logic [out_trig_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [out_trig_pkg::NUM_PINS-1:0] pin_oe_n,
  output logic [out_trig_pkg::NUM_PINS-1:0] pin_in,
  output logic analog_in_reference_trigger,
  output logic analog_in_start_trigger,
  output logic internal_event
);
  logic [out_trig_pkg::NUM_PINS-1:0] drive;

  // sources move one edge after a request, like same-clock logic would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
      analog_in_reference_trigger <= 1'b0;
      analog_in_start_trigger <= 1'b0;
      internal_event <= 1'b0;
    end else begin
      drive <= req_pin;
      analog_in_reference_trigger <= req_ref;
      analog_in_start_trigger <= req_start;
      internal_event <= req_int;
    end
  end

  // a pin the block drives shows its own level, so the source must yield
  always_comb begin
    for (int i = 0; i < out_trig_pkg::NUM_PINS; i++) begin
      pin_in[i] = pin_oe_n[i] ? drive[i] : pin_out[i];
    end
  end
endmodule

// ==== verification/output_timing_trigger_filter_tb.sv ====
`timescale 1ns/1ns
module output_timing_trigger_filter_tb;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic ai_ref;
  logic ai_start;
  logic int_ev;
  logic [3:0] req_pin;
  logic req_ref;
  logic req_start;
  logic req_int;
  logic do_update;
  logic [7:0] do_data;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int comparisons = 0;
  int upd_count = 0;
  int cyc = 0;
  int last_upd = 0;
  int gap = 0;
  int p1_high = 0;
  int p2_high = 0;

  output_timing_trigger_filter output_timing_trigger_filter_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .analog_in_reference_trigger(ai_ref), .analog_in_start_trigger(ai_start), .internal_event(int_ev),
    .do_update(do_update), .do_data(do_data));

  trig_source_model trig_source_model_i (.pclk(pclk), .presetn(presetn), .req_pin(req_pin), .req_ref(req_ref),
    .req_start(req_start), .req_int(req_int), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
    .analog_in_reference_trigger(ai_ref), .analog_in_start_trigger(ai_start), .internal_event(int_ev));

  // -----------------------------------------------------------------
  // clock, monitors and helpers
  // -----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // counts update pulses, their spacing and routed pin pulses
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (do_update === 1'b1) begin
      upd_count <= upd_count + 1;
      gap <= cyc - last_upd;
      last_upd <= cyc;
    end
    if (pin_out[1] === 1'b1) p1_high <= p1_high + 1;
    if (pin_out[2] === 1'b1) p2_high <= p2_high + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one transfer; the access phase is held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait limit here: only the watchdog may end a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_state(input string name, input logic [1:0] s);
    apb(1'b0, out_trig_pkg::REG_STATUS, 32'h0);
    check(name, {30'h0, rd[1:0]}, {30'h0, s});
  endtask

  task automatic go(input logic [31:0] trig);
    wr(out_trig_pkg::REG_CTRL, 32'h4);
    wr(out_trig_pkg::REG_TRIG, trig);
    wr(out_trig_pkg::REG_CTRL, 32'h1);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, out_trig_pkg::REG_DIV, 32'h0);
    check("div reset", rd, 32'h0000_0010);
    apb(1'b0, out_trig_pkg::REG_FILTER, 32'h0);
    check("filter reset", rd, 32'h0);
    check("pins released", {28'h0, pin_oe_n}, 32'hF);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask

  task automatic t_sw_start();
    int n0;
    wr(out_trig_pkg::REG_DIV, 32'h2);
    wr(out_trig_pkg::REG_DATA, 32'hA5);
    go(32'h0);
    n0 = upd_count;
    idle(10);
    check("no update before start", 32'(upd_count - n0), 32'h0);
    wr(out_trig_pkg::REG_CTRL, 32'h2);
    idle(12);
    check("divided spacing", 32'(gap), 32'h2);
    check("data on strobe", {24'h0, do_data}, 32'hA5);
    chk_state("sw start run", 2'h3);
    wr(out_trig_pkg::REG_CTRL, 32'h4);
    n0 = upd_count;
    idle(10);
    check("stopped", 32'(upd_count - n0), 32'h0);
  endtask

  task automatic t_delay();
    int n0;
    wr(out_trig_pkg::REG_DELAY, 32'h0000_001E);
    go(32'h0);
    n0 = upd_count;
    wr(out_trig_pkg::REG_CTRL, 32'h2);
    idle(5);
    chk_state("in delay", 2'h2);
    check("quiet in delay", 32'(upd_count - n0), 32'h0);
    idle(30);
    chk_state("delay done", 2'h3);
    wr(out_trig_pkg::REG_DELAY, 32'h0);
  endtask

  task automatic t_pause_internal();
    int n0;
    wr(out_trig_pkg::REG_DIV, 32'h4);
    req_ref <= 1'b1;
    go(32'h0110_0000);
    wr(out_trig_pkg::REG_CTRL, 32'h2);
    n0 = upd_count;
    idle(20);
    check("paused high", 32'(upd_count - n0), 32'h0);
    apb(1'b0, out_trig_pkg::REG_STATUS, 32'h0);
    check("paused flag", {31'h0, rd[2]}, 32'h1);
    req_ref <= 1'b0;
    n0 = upd_count;
    idle(8);
    check("onboard resume", {31'h0, upd_count > n0}, 32'h1);
    go(32'h0310_0000);
    wr(out_trig_pkg::REG_CTRL, 32'h2);
    n0 = upd_count;
    idle(20);
    check("paused low", 32'(upd_count - n0), 32'h0);
  endtask

  task automatic pulse_int();
    req_int <= 1'b1;
    idle(4);
    req_int <= 1'b0;
    idle(4);
  endtask

  task automatic t_ext_strobe();
    int n0;
    go(32'h0110_3100);
    wr(out_trig_pkg::REG_CTRL, 32'h2);
    n0 = upd_count;
    pulse_int();
    check("external edge", 32'(upd_count - n0), 32'h1);
    req_ref <= 1'b1;
    idle(3);
    pulse_int();
    check("edge lost in pause", 32'(upd_count - n0), 32'h1);
    req_ref <= 1'b0;
    idle(10);
    check("no resume without edge", 32'(upd_count - n0), 32'h1);
    pulse_int();
    check("resume on edge", 32'(upd_count - n0), 32'h2);
  endtask

  task automatic t_edge_start();
    go(32'h0000_0015);
    req_ref <= 1'b1;
    idle(5);
    chk_state("rising ignored", 2'h1);
    req_ref <= 1'b0;
    idle(5);
    chk_state("falling starts", 2'h3);
    go(32'h0000_0021);
    req_start <= 1'b1;
    idle(5);
    chk_state("rising starts", 2'h3);
    req_start <= 1'b0;
  endtask

  task automatic t_time_start();
    go(32'h0000_0002);
    apb(1'b0, out_trig_pkg::REG_NOW, 32'h0);
    wr(out_trig_pkg::REG_START_TIME, rd + 32'h0000_00C8);
    idle(100);
    chk_state("before time", 2'h1);
    idle(120);
    chk_state("after time", 2'h3);
  endtask

  task automatic t_route();
    int s1;
    int s2;
    int n0;
    wr(out_trig_pkg::REG_PINS, 32'h0000_0186);
    // the enables are registered one cycle after the write lands
    idle(1);
    check("pin enables", {28'h0, pin_oe_n}, 32'h9);
    go(32'h0);
    s1 = p1_high;
    s2 = p2_high;
    n0 = upd_count;
    wr(out_trig_pkg::REG_CTRL, 32'h2);
    idle(10);
    check("start pulse width", 32'(p1_high - s1), 32'h1);
    check("strobe on pin", 32'(p2_high - s2), 32'(upd_count - n0));
  endtask

  task automatic t_filter();
    wr(out_trig_pkg::REG_FILTER, 32'h0001_0131);
    go(32'h0000_0081);
    req_pin[0] <= 1'b1;
    idle(2);
    req_pin[0] <= 1'b0;
    idle(12);
    chk_state("glitch rejected", 2'h1);
    req_pin[0] <= 1'b1;
    idle(15);
    apb(1'b0, out_trig_pkg::REG_STATUS, 32'h0);
    check("filtered rise", {31'h0, rd[4]}, 32'h1);
    check("filtered start", {30'h0, rd[1:0]}, 32'h3);
    req_pin[0] <= 1'b0;
    idle(15);
    apb(1'b0, out_trig_pkg::REG_STATUS, 32'h0);
    check("filtered fall", {31'h0, rd[4]}, 32'h0);
    wr(out_trig_pkg::REG_FILTER, 32'h0000_0001);
    req_pin[0] <= 1'b1;
    idle(6);
    req_pin[0] <= 1'b0;
    idle(12);
    apb(1'b0, out_trig_pkg::REG_STATUS, 32'h0);
    check("short preset rejects", {31'h0, rd[4]}, 32'h0);
    req_pin[0] <= 1'b1;
    idle(14);
    apb(1'b0, out_trig_pkg::REG_STATUS, 32'h0);
    check("short preset passes", {31'h0, rd[4]}, 32'h1);
  endtask

  // -----------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_pin = 4'h0;
    req_ref = 1'b0;
    req_start = 1'b0;
    req_int = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_sw_start();
    t_delay();
    t_pause_internal();
    t_ext_strobe();
    t_edge_start();
    t_time_start();
    t_route();
    t_filter();
    end_of_test();
  end

  // the scenarios need about 700 cycles; a hang is cut well beyond that
  initial begin
    repeat (6000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
endmodule
